// [hw/cabx_exec.v]
// cabx_exec.v: execute unit for arithmetic, jump, skip and branch ops
// assumes: AXI4-Lite master issues commands; program counter, stack,
// status flags and the 32-byte register file live here
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "cabx_regs.vh"

module cabx_exec (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  // -----------------------------------------------------------------
  // reset release
  // -----------------------------------------------------------------
  reg rst_m_q;
  reg rst_s_q;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // -----------------------------------------------------------------
  // architectural state
  // -----------------------------------------------------------------
  reg  [7:0]  rf [0:31];
  reg  [15:0] stk [0:15];
  reg  [15:0] pc_q;
  reg  [3:0]  sp_q;
  reg  [7:0]  flags_q;
  reg  [7:0]  io_q;
  reg  [15:0] arg_q;
  reg  [18:0] cmd_q;
  reg  [1:0]  state_q;
  reg  [2:0]  cnt_q;
  reg  [2:0]  last_n_q;

  wire busy = state_q[1];

  // -----------------------------------------------------------------
  // write channel holding
  // -----------------------------------------------------------------
  reg  [7:0]  aw_q;
  reg         aw_v_q;
  reg  [31:0] wd_q;
  reg  [3:0]  ws_q;
  reg         w_v_q;

  wire wr_go   = aw_v_q & w_v_q & ~s_axi_bvalid;
  wire wr_lane = |ws_q;
  wire in_rf   = aw_q[`CABX_RF_WIN] & (aw_q[1:0] == 2'h0);
  // an all-zero strobe stores nothing, so it starts nothing either
  wire start   = wr_go & (aw_q == `CABX_A_CMD) & ~busy & wr_lane;
  wire rf_wr   = wr_go & in_rf & ~busy & wr_lane;

  // -----------------------------------------------------------------
  // command decode, taken from the write data as it is accepted
  // -----------------------------------------------------------------
  wire [4:0]  c_op  = wd_q[`CABX_CMD_OP];
  wire [4:0]  c_rd  = wd_q[`CABX_CMD_RD];
  wire [4:0]  c_rr  = wd_q[`CABX_CMD_RR];
  wire [2:0]  c_bit = wd_q[`CABX_CMD_BIT];
  wire        c_two = wd_q[`CABX_CMD_TWO];
  wire [7:0]  rd_v  = rf[c_rd];
  wire [7:0]  rr_v  = rf[c_rr];
  wire [15:0] zptr  = {rf[31], rf[30]};
  wire [15:0] pc_rel = pc_q + arg_q + 16'h0001;
  wire [3:0]  sp_top = sp_q - 4'h1;

  wire [7:0]  a_res;
  wire        a_res_we;
  wire [15:0] a_prod;
  wire        a_prod_we;
  wire [7:0]  a_fl;

  cabx_alu u_alu (
    .op      (c_op),
    .a       (rd_v),
    .b       (rr_v),
    .k       (arg_q[7:0]),
    .fin     (flags_q),
    .res     (a_res),
    .res_we  (a_res_we),
    .prod    (a_prod),
    .prod_we (a_prod_we),
    .fout    (a_fl)
  );

  // -----------------------------------------------------------------
  // program flow and cycle count
  // -----------------------------------------------------------------
  reg [15:0] pc_d;
  reg [15:0] link_d;
  reg [2:0]  n_d;
  reg        push_d;
  reg        pop_d;
  reg        skip_d;
  reg        take_d;

  always @* begin
    pc_d   = pc_q + 16'h0001;
    link_d = pc_q + 16'h0001;
    n_d    = `CABX_N1;
    push_d = 1'b0;
    pop_d  = 1'b0;
    skip_d = 1'b0;
    take_d = 1'b0;
    case (c_op)
      `CABX_OP_PRODU, `CABX_OP_PRODS, `CABX_OP_PRODSU,
      `CABX_OP_FPRODU, `CABX_OP_FPRODS, `CABX_OP_FPRODM:
        n_d = `CABX_N2;
      `CABX_OP_RELJ: begin
        pc_d = pc_rel;
        n_d  = `CABX_N2;
      end
      `CABX_OP_PTRJ: begin
        pc_d = zptr;
        n_d  = `CABX_N2;
      end
      `CABX_OP_ABSJ: begin
        pc_d = arg_q;
        n_d  = `CABX_N3;
      end
      `CABX_OP_RELE: begin
        pc_d   = pc_rel;
        n_d    = `CABX_N3;
        push_d = 1'b1;
      end
      `CABX_OP_PTRE: begin
        pc_d   = zptr;
        n_d    = `CABX_N3;
        push_d = 1'b1;
      end
      `CABX_OP_ABSE: begin
        // two-word entry: resume after both words
        pc_d   = arg_q;
        link_d = pc_q + 16'h0002;
        n_d    = `CABX_N4;
        push_d = 1'b1;
      end
      `CABX_OP_SEXIT: begin
        pc_d  = stk[sp_top];
        n_d   = `CABX_N4;
        pop_d = 1'b1;
      end
      `CABX_OP_CSKIP: skip_d = (rd_v == rr_v);
      `CABX_OP_SKRB0: skip_d = ~rr_v[c_bit];
      `CABX_OP_SKRB1: skip_d = rr_v[c_bit];
      `CABX_OP_SKIB0: skip_d = ~io_q[c_bit];
      `CABX_OP_SKIB1: skip_d = io_q[c_bit];
      // named branches are these two with a fixed flag bit
      `CABX_OP_BRFS: take_d = flags_q[c_bit];
      `CABX_OP_BRFC: take_d = ~flags_q[c_bit];
      default: ;
    endcase
    if (skip_d) begin
      pc_d = c_two ? pc_q + 16'h0003 : pc_q + 16'h0002;
      n_d  = c_two ? `CABX_N3 : `CABX_N2;
    end
    if (take_d) begin
      pc_d = pc_rel;
      n_d  = `CABX_N2;
    end
  end

  // -----------------------------------------------------------------
  // register file and stack memories
  // -----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (start && a_res_we) begin
      rf[c_rd] <= a_res;
    end
    if (start && a_prod_we) begin
      rf[0] <= a_prod[7:0];
      rf[1] <= a_prod[15:8];
    end
    if (rf_wr) begin
      rf[aw_q[6:2]] <= wd_q[7:0];
    end
    if (start && push_d) begin
      stk[sp_q] <= link_d;
    end
  end

  // -----------------------------------------------------------------
  // execute state: commit at issue, busy for the cycle count
  // -----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 3'h0;
      last_n_q <= 3'h0;
      pc_q     <= `CABX_PC_RST;
      sp_q     <= `CABX_SP_RST;
      flags_q  <= `CABX_FLAG_RST;
      cmd_q    <= 19'h00000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q  <= ST_RUN;
            cnt_q    <= n_d - 3'h1;
            last_n_q <= n_d;
            cmd_q    <= wd_q[18:0];
            pc_q     <= pc_d;
            // jumps, skips and branches leave flags alone
            flags_q  <= a_fl;
            if (push_d) begin
              sp_q <= sp_q + 4'h1;
            end else if (pop_d) begin
              sp_q <= sp_top;
            end
          end else if (wr_go && wr_lane) begin
            if (aw_q == `CABX_A_FLAG) begin
              flags_q <= wd_q[7:0];
            end else if (aw_q == `CABX_A_PC) begin
              pc_q <= wd_q[15:0];
            end
          end
        end
        ST_RUN: begin
          if (cnt_q == 3'h0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // AXI4-Lite write path
  // -----------------------------------------------------------------
  // command, flag, PC and register-file writes are refused while an op is in flight
  wire wr_ok = (aw_q == `CABX_A_ARG) | (aw_q == `CABX_A_IO) |
               (~busy & ((aw_q == `CABX_A_CMD) | (aw_q == `CABX_A_FLAG) |
                         (aw_q == `CABX_A_PC) | in_rf));

  always @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CABX_RESP_OK;
      aw_v_q        <= 1'b0;
      w_v_q         <= 1'b0;
      aw_q          <= 8'h00;
      wd_q          <= 32'h00000000;
      ws_q          <= 4'h0;
      arg_q         <= 16'h0000;
      io_q          <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q          <= s_axi_awaddr;
        aw_v_q        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q         <= s_axi_wdata;
        ws_q         <= s_axi_wstrb;
        w_v_q        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_v_q       <= 1'b0;
        w_v_q        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `CABX_RESP_OK : `CABX_RESP_ERR;
        if (wr_lane && aw_q == `CABX_A_ARG) begin
          arg_q <= wd_q[15:0];
        end
        if (wr_lane && aw_q == `CABX_A_IO) begin
          io_q <= wd_q[7:0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // AXI4-Lite read path
  // -----------------------------------------------------------------
  reg [31:0] rd_mux;
  reg        rd_bad;

  always @* begin
    rd_mux = 32'h00000000;
    rd_bad = 1'b0;
    if (s_axi_araddr[`CABX_RF_WIN] && s_axi_araddr[1:0] == 2'h0) begin
      rd_mux = {24'h000000, rf[s_axi_araddr[6:2]]};
    end else if (s_axi_araddr == `CABX_A_CMD) begin
      rd_mux = {13'h0000, cmd_q};
    end else if (s_axi_araddr == `CABX_A_ARG) begin
      rd_mux = {16'h0000, arg_q};
    end else if (s_axi_araddr == `CABX_A_STAT) begin
      rd_mux = {13'h0000, last_n_q, flags_q, 7'h00, busy};
    end else if (s_axi_araddr == `CABX_A_FLAG) begin
      rd_mux = {24'h000000, flags_q};
    end else if (s_axi_araddr == `CABX_A_PC) begin
      rd_mux = {16'h0000, pc_q};
    end else if (s_axi_araddr == `CABX_A_SP) begin
      rd_mux = {28'h0000000, sp_q};
    end else if (s_axi_araddr == `CABX_A_IO) begin
      rd_mux = {24'h000000, io_q};
    end else begin
      rd_bad = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CABX_RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_bad ? `CABX_RESP_ERR : `CABX_RESP_OK;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // cabx_exec

// [hw/cabx_regs.vh]
// cabx_regs.vh: constants of the arithmetic and branch execute block
// assumes: included by cabx_exec.v and cabx_alu.v, one clock domain
`ifndef CABX_REGS_VH
`define CABX_REGS_VH

// -----------------------------------------------------------------
// register map (byte addresses)
// -----------------------------------------------------------------
`define CABX_A_CMD    8'h00
`define CABX_A_ARG    8'h04
`define CABX_A_STAT   8'h08
`define CABX_A_FLAG   8'h0c
`define CABX_A_PC     8'h10
`define CABX_A_SP     8'h14
`define CABX_A_IO     8'h18
`define CABX_RF_WIN   7
`define CABX_RESP_OK  2'h0
`define CABX_RESP_ERR 2'h2

// -----------------------------------------------------------------
// command word fields
// -----------------------------------------------------------------
`define CABX_CMD_OP   4:0
`define CABX_CMD_RD   9:5
`define CABX_CMD_RR   14:10
`define CABX_CMD_BIT  17:15
`define CABX_CMD_TWO  18

// -----------------------------------------------------------------
// operation codes
// -----------------------------------------------------------------
`define CABX_OP_ADD1   5'h00
`define CABX_OP_SUB1   5'h01
`define CABX_OP_ZTEST  5'h02
`define CABX_OP_ZERO   5'h03
`define CABX_OP_ONES   5'h04
`define CABX_OP_PRODU  5'h05
`define CABX_OP_PRODS  5'h06
`define CABX_OP_PRODSU 5'h07
`define CABX_OP_FPRODU 5'h08
`define CABX_OP_FPRODS 5'h09
`define CABX_OP_FPRODM 5'h0a
`define CABX_OP_RELJ   5'h0b
`define CABX_OP_PTRJ   5'h0c
`define CABX_OP_ABSJ   5'h0d
`define CABX_OP_RELE   5'h0e
`define CABX_OP_PTRE   5'h0f
`define CABX_OP_ABSE   5'h10
`define CABX_OP_SEXIT  5'h11
`define CABX_OP_CSKIP  5'h12
`define CABX_OP_CMPC   5'h13
`define CABX_OP_CMPK   5'h14
`define CABX_OP_SKRB0  5'h15
`define CABX_OP_SKRB1  5'h16
`define CABX_OP_SKIB0  5'h17
`define CABX_OP_SKIB1  5'h18
`define CABX_OP_BRFS   5'h19
`define CABX_OP_BRFC   5'h1a

// -----------------------------------------------------------------
// status flag bits, reset values, cycle counts
// -----------------------------------------------------------------
`define CABX_F_C      0
`define CABX_F_Z      1
`define CABX_F_N      2
`define CABX_F_V      3
`define CABX_F_S      4
`define CABX_F_H      5
`define CABX_F_T      6
`define CABX_F_I      7
`define CABX_FLAG_RST 8'h00
`define CABX_PC_RST   16'h0000
`define CABX_SP_RST   4'h0
`define CABX_ONES_VAL 8'hff
`define CABX_N1       3'h1
`define CABX_N2       3'h2
`define CABX_N3       3'h3
`define CABX_N4       3'h4

`endif

// [hw/cabx_alu.v]
// cabx_alu.v: data path for single-operand, product and compare ops
// assumes: purely combinational, used by cabx_exec
`timescale 1ns/1ps
`include "cabx_regs.vh"

module cabx_alu (
  // operation and operands
  input  wire [4:0]  op,
  input  wire [7:0]  a,
  input  wire [7:0]  b,
  input  wire [7:0]  k,
  input  wire [7:0]  fin,
  // results
  output reg  [7:0]  res,
  output reg         res_we,
  output reg  [15:0] prod,
  output reg         prod_we,
  output reg  [7:0]  fout
);

  // -----------------------------------------------------------------
  // product: 9-bit sign extension covers all three signednesses
  // -----------------------------------------------------------------
  wire sa = (op == `CABX_OP_PRODS) || (op == `CABX_OP_PRODSU) ||
            (op == `CABX_OP_FPRODS) || (op == `CABX_OP_FPRODM);
  wire sb = (op == `CABX_OP_PRODS) || (op == `CABX_OP_FPRODS);
  wire signed [8:0]  pa = {sa & a[7], a};
  wire signed [8:0]  pb = {sb & b[7], b};
  wire signed [17:0] pf = pa * pb;

  // -----------------------------------------------------------------
  // compare: subtract without write-back
  // -----------------------------------------------------------------
  wire [7:0] so   = (op == `CABX_OP_CMPK) ? k : b;
  wire       cin  = (op == `CABX_OP_CMPC) & fin[`CABX_F_C];
  wire [7:0] diff = a - so - {7'h00, cin};
  wire [7:0] brw  = (~a & so) | (so & diff) | (diff & ~a);
  wire       cv   = (a[7] & ~so[7] & ~diff[7]) | (~a[7] & so[7] & diff[7]);

  reg nzv;
  reg v;

  always @* begin
    nzv     = 1'b0;
    v       = 1'b0;
    res     = a;
    res_we  = 1'b0;
    prod    = pf[15:0];
    prod_we = 1'b0;
    fout    = fin;
    case (op)
      `CABX_OP_ADD1: begin
        res = a + 8'h01;
        v   = (a == 8'h7f);
        nzv = 1'b1;
      end
      `CABX_OP_SUB1: begin
        res = a - 8'h01;
        v   = (a == 8'h80);
        nzv = 1'b1;
      end
      `CABX_OP_ZTEST: nzv = 1'b1;
      `CABX_OP_ZERO: begin
        res = 8'h00;
        nzv = 1'b1;
      end
      `CABX_OP_ONES: res = `CABX_ONES_VAL;
      `CABX_OP_PRODU, `CABX_OP_PRODS, `CABX_OP_PRODSU: prod_we = 1'b1;
      `CABX_OP_FPRODU, `CABX_OP_FPRODS, `CABX_OP_FPRODM: begin
        prod    = {pf[14:0], 1'b0};
        prod_we = 1'b1;
      end
      `CABX_OP_CMPC, `CABX_OP_CMPK: begin
        fout[`CABX_F_C] = brw[7];
        fout[`CABX_F_H] = brw[3];
        fout[`CABX_F_N] = diff[7];
        fout[`CABX_F_V] = cv;
        fout[`CABX_F_S] = diff[7] ^ cv;
        // carry compare chains zero across bytes
        fout[`CABX_F_Z] = (diff == 8'h00) &
                          ((op == `CABX_OP_CMPK) | fin[`CABX_F_Z]);
      end
      default: ;
    endcase
    res_we = nzv | (op == `CABX_OP_ONES);
    if (nzv) begin
      fout[`CABX_F_N] = res[7];
      fout[`CABX_F_Z] = (res == 8'h00);
      fout[`CABX_F_V] = v;
      fout[`CABX_F_S] = res[7] ^ v;
    end
    if (prod_we) begin
      fout[`CABX_F_C] = pf[15];
      fout[`CABX_F_Z] = (prod == 16'h0000);
    end
  end

endmodule // cabx_alu

// [testbench/cabx_exec_checker.sv]
// cabx_exec_checker.sv: bus timing and status checks for cabx_exec
// assumes: bound to cabx_exec, one clock domain, async active-low reset
`timescale 1ns/1ps

module cabx_exec_checker (
  // clock and reset
  input logic        sys_clk,
  input logic        rst_n,
  // write channels
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  // read channels
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // -----------------------------------------------------------------
  // address of the read under way
  // -----------------------------------------------------------------
  logic [7:0] ar_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      ar_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      ar_q <= s_axi_araddr;
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  a_bresp_delay: assert property ((s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready) |-> !s_axi_bvalid ##1 !s_axi_bvalid
    ##1 s_axi_bvalid) else $error("write answer not two cycles late");
  a_bvalid_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_rvalid_next: assert property ((s_axi_arvalid && s_axi_arready) |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rdata_hold: assert property ((s_axi_rvalid && !s_axi_rready) |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data moved before taken");
  a_ready_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready during answer");
  a_ready_return: assert property ((s_axi_bvalid && s_axi_bready) |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  a_rvalid_drop: assert property ((s_axi_rvalid && s_axi_rready) |=>
    !s_axi_rvalid && s_axi_arready) else $error("read channel not freed");
  a_unmapped_err: assert property ((s_axi_rvalid && ar_q >= 8'h1c &&
    ar_q < 8'h80) |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_stat_count: assert property ((s_axi_rvalid && ar_q == 8'h08) |->
    s_axi_rdata[18:16] <= 3'h4 && s_axi_rdata[31:19] == 13'h0)
    else $error("cycle count out of range");
endmodule // cabx_exec_checker

bind cabx_exec cabx_exec_checker chk (.*);

// [testbench/cabx_exec_tb.sv]
// cabx_exec_tb.sv: self-checking bench for the execute block
// assumes: design and checker compiled first, 20 MHz clock
`timescale 1ns/1ps

module cabx_exec_tb;
  logic        sys_clk, rst_n;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data;
  logic [3:0]  w_strb;
  logic [1:0]  b_resp, r_resp, rd_resp;
  logic        aw_vld, aw_rdy, w_vld, w_rdy, b_vld, b_rdy;
  logic        ar_vld, ar_rdy, r_vld, r_rdy;
  int          mismatches, total_checks;

  cabx_exec uut (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .s_axi_awaddr  (aw_addr),
    .s_axi_awvalid (aw_vld),
    .s_axi_awready (aw_rdy),
    .s_axi_wdata   (w_data),
    .s_axi_wstrb   (w_strb),
    .s_axi_wvalid  (w_vld),
    .s_axi_wready  (w_rdy),
    .s_axi_bresp   (b_resp),
    .s_axi_bvalid  (b_vld),
    .s_axi_bready  (b_rdy),
    .s_axi_araddr  (ar_addr),
    .s_axi_arvalid (ar_vld),
    .s_axi_arready (ar_rdy),
    .s_axi_rdata   (r_data),
    .s_axi_rresp   (r_resp),
    .s_axi_rvalid  (r_vld),
    .s_axi_rready  (r_rdy)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [31:0] mk(input logic [4:0] op,
    input logic [4:0] d, input logic [4:0] r, input logic [2:0] b,
    input logic two);
    mk = {13'h0, two, b, r, d, op};
  endfunction

  function automatic logic [7:0] ra(input int n);
    ra = 8'h80 + 8'(4 * n);
  endfunction

  // address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] exp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge sys_clk);
    aw_addr <= a;
    w_data <= d;
    aw_vld <= 1'b1;
    w_vld <= 1'b1;
    b_rdy <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (!aw_done && aw_rdy) begin
        aw_vld <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && w_rdy) begin
        w_vld <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!b_vld) @(posedge sys_clk);
    check("bresp", {30'h0, b_resp}, {30'h0, exp});
    b_rdy <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    ar_addr <= a;
    ar_vld <= 1'b1;
    r_rdy <= 1'b1;
    do @(posedge sys_clk); while (!ar_rdy);
    ar_vld <= 1'b0;
    do @(posedge sys_clk); while (!r_vld);
    d = r_data;
    rd_resp = r_resp;
    r_rdy <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    check($sformatf("addr %h", a), v & m, e);
  endtask

  // busy is polled, bounded, then the recorded cycle count judged
  task automatic run_op(input logic [31:0] cmd, input logic [2:0] nc);
    logic [31:0] st;
    int n;
    wr(8'h00, cmd, 2'h0);
    n = 0;
    do begin
      rd(8'h08, st);
      n++;
    end while (st[0] !== 1'b0 && n < 10);
    check("stat", {28'h0, st[18:16], st[0]}, {28'h0, nc, 1'b0});
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_bus;
    logic [31:0] v;
    rd(8'h40, v);
    check("unmapped", {rd_resp, v}, {2'h2, 32'h0});
    wr(8'h08, 32'h1, 2'h2);
    wr(8'h44, 32'h1, 2'h2);
    wr(ra(2), 32'h11, 2'h0);
    w_strb <= 4'h0;
    wr(ra(2), 32'h55, 2'h0);
    w_strb <= 4'hf;
    rd_chk(ra(2), 32'hff, 32'h11);
  endtask

  task automatic t_single;
    logic [7:0] r[4] = '{8'h80, 8'h7f, 8'h7f, 8'h00};
    logic [7:0] f[4] = '{8'h0c, 8'h08, 8'h00, 8'h02};
    wr(ra(3), 32'h7f, 2'h0);
    for (int i = 0; i < 4; i++) begin
      run_op(mk(5'(i), 5'd3, 5'd0, 3'd0, 1'b0), 3'd1);
      rd_chk(ra(3), 32'hff, {24'h0, r[i]});
      rd_chk(8'h0c, 32'h0e, {24'h0, f[i]});
    end
    wr(8'h0c, 32'h5a, 2'h0);
    run_op(mk(5'h04, 5'd3, 5'd0, 3'd0, 1'b0), 3'd1);
    rd_chk(ra(3), 32'hff, 32'hff);
    rd_chk(8'h0c, 32'hff, 32'h5a);
  endtask

  task automatic t_mul;
    logic [15:0] p[6] = '{16'hfe01, 16'h0001, 16'hff01,
                          16'hfc02, 16'h0002, 16'hfe02};
    logic [31:0] lo, hi;
    wr(ra(16), 32'hff, 2'h0);
    wr(ra(17), 32'hff, 2'h0);
    for (int i = 0; i < 7; i++) begin
      if (i == 6)
        wr(ra(16), 32'h00, 2'h0);
      wr(8'h0c, 32'hfc, 2'h0);
      run_op(mk(5'(5 + i % 6), 5'd16, 5'd17, 3'd0, 1'b0), 3'd2);
      rd(ra(0), lo);
      rd(ra(1), hi);
      check("product", {hi[7:0], lo[7:0]}, i < 6 ? p[i] : 16'h0);
      rd_chk(8'h0c, 32'hff, i < 6 ? {31'h7e, p[i] > 16'h0002} :
        32'hfe);
    end
  endtask

  task automatic t_flow;
    logic [4:0]  op[9] = '{5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h10, 5'h11,
                           5'h0f, 5'h11, 5'h11};
    logic [15:0] pc[9] = '{16'h00f1, 16'h1234, 16'h0abc, 16'h0211,
                           16'h0500, 16'h0213, 16'h1234, 16'h0214,
                           16'h0201};
    logic [15:0] ag[9] = '{16'hfff0, 16'hfff0, 16'h0abc, 16'h0010,
                           16'h0500, 16'h0500, 16'h0500, 16'h0500,
                           16'h0500};
    int nc[9] = '{2, 2, 3, 3, 4, 4, 3, 4, 4};
    int sp[9] = '{0, 0, 0, 1, 2, 1, 2, 1, 0};
    wr(ra(30), 32'h34, 2'h0);
    wr(ra(31), 32'h12, 2'h0);
    wr(8'h0c, 32'haa, 2'h0);
    wr(8'h10, 32'h0100, 2'h0);
    for (int i = 0; i < 9; i++) begin
      if (i == 3)
        wr(8'h10, 32'h0200, 2'h0);
      wr(8'h04, {16'h0, ag[i]}, 2'h0);
      run_op(mk(op[i], 5'd0, 5'd0, 3'd0, 1'b0), 3'(nc[i]));
      rd_chk(8'h10, 32'hffff, {16'h0, pc[i]});
      rd_chk(8'h14, 32'hf, 32'(sp[i]));
    end
    rd_chk(8'h0c, 32'hff, 32'haa);
  endtask

  task automatic t_skip;
    logic [4:0] op[8] = '{5'h12, 5'h12, 5'h12, 5'h15, 5'h16, 5'h16,
                          5'h18, 5'h17};
    int rr[8] = '{6, 6, 7, 5, 5, 5, 0, 0};
    int bt[8] = '{0, 0, 0, 0, 0, 2, 7, 7};
    int tw[8] = '{0, 1, 0, 0, 0, 1, 0, 1};
    int nc[8] = '{2, 3, 1, 2, 1, 3, 2, 1};
    logic [31:0] p;
    wr(ra(5), 32'h3c, 2'h0);
    wr(ra(6), 32'h3c, 2'h0);
    wr(ra(7), 32'h3d, 2'h0);
    wr(8'h18, 32'h80, 2'h0);
    wr(8'h0c, 32'h33, 2'h0);
    wr(8'h10, 32'h0040, 2'h0);
    for (int i = 0; i < 8; i++) begin
      rd(8'h10, p);
      run_op(mk(op[i], 5'd5, 5'(rr[i]), 3'(bt[i]), tw[i][0]),
             3'(nc[i]));
      rd_chk(8'h10, 32'hffff, p + 32'(nc[i]));
    end
    rd_chk(8'h0c, 32'hff, 32'h33);
  endtask

  // each flag bit, both polarities, both senses of the branch
  task automatic t_branch;
    logic [7:0] fl;
    logic tk;
    wr(8'h04, 32'h0005, 2'h0);
    for (int i = 0; i < 32; i++) begin
      fl = i[4] ? 8'haa : 8'h55;
      tk = fl[i[3:1]] ^ i[0];
      wr(8'h0c, {24'h0, fl}, 2'h0);
      wr(8'h10, 32'h0100, 2'h0);
      run_op(mk(i[0] ? 5'h1a : 5'h19, 5'd0, 5'd0, i[3:1], 1'b0),
             tk ? 3'd2 : 3'd1);
      rd_chk(8'h10, 32'hffff, tk ? 32'h0106 : 32'h0101);
      rd_chk(8'h0c, 32'hff, {24'h0, fl});
    end
  endtask

  task automatic t_cmp;
    wr(ra(7), 32'h10, 2'h0);
    wr(ra(8), 32'h10, 2'h0);
    wr(8'h04, 32'h20, 2'h0);
    wr(8'h0c, 32'h00, 2'h0);
    run_op(mk(5'h14, 5'd7, 5'd0, 3'd0, 1'b0), 3'd1);
    rd_chk(8'h0c, 32'h3f, 32'h15);
    run_op(mk(5'h13, 5'd7, 5'd8, 3'd0, 1'b0), 3'd1);
    rd_chk(8'h0c, 32'h3f, 32'h35);
    rd_chk(ra(7), 32'hff, 32'h10);
    rd_chk(8'h00, 32'h7ffff, mk(5'h13, 5'd7, 5'd8, 3'd0, 1'b0));
  endtask

  // -----------------------------------------------------------------
  // main sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {aw_addr, ar_addr, w_data} = '0;
    w_strb = 4'hf;
    {aw_vld, w_vld, b_rdy, ar_vld, r_rdy} = '0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    t_bus;
    t_single;
    t_mul;
    t_flow;
    t_skip;
    t_branch;
    t_cmp;
    finish_test;
  end

  // traffic needs about 1500 cycles; sixteen times that as margin
  initial begin
    repeat (24000) @(posedge sys_clk);
    mismatches++;
    finish_test;
  end
endmodule // cabx_exec_tb
